// *** bench/rpcr_term.sv ***
// Serial terminal model on the far side of the remote power receive line.
// Assumes 8N1, LSB first; the terminal keeps the line driven high between frames.
`timescale 1ns/100ps
module rpcr_term (
    // clock
    input  wire logic clk,
    // serial line
    output logic      ser_rxd
);
    initial ser_rxd = 1'b1;

    // ----------------------------------------------------------------
    // frame and command senders
    // ----------------------------------------------------------------
    // one frame, p clocks a bit, changes at the falling edge, then gap idle clocks
    task automatic send_byte(input logic [7:0] b, input int p, input int gap);
        logic [9:0] frame;
        int         i;
        int         k;
        frame = {1'b1, b, 1'b0};
        for (i = 0; i < 10; i++)
        begin
            ser_rxd = frame[i];
            for (k = 0; k < p; k++) @(negedge clk);
        end
        for (k = 0; k < gap; k++) @(negedge clk);
    endtask

    // escape-led command text, then carriage return; escape first keeps the
    // start bit measurement clean because its low bit is one
    task automatic send_cmd(input logic [79:0] s, input int len, input int p, input int gap);
        int i;
        for (i = 0; i < len; i++)
            send_byte(s[8*(len-1-i) +: 8], p, gap);
        send_byte(rpcr_pkg::CH_CR, p, gap);
    endtask
endmodule

// *** bench/tb_remote_power_command_receiver.sv ***
// Self-checking bench of the remote power command receiver.
// Assumes the terminal model drives the line; firmware inputs come from here.
`timescale 1ns/100ps
module tb_remote_power_command_receiver;
    logic       sys_clk;
    logic       rst;
    logic       ser_rxd;
    logic       jumper_en;
    logic       permit;
    logic       shutdown_done;
    logic       sys_power_on;
    logic       soft_off_req;
    logic       ctrl_sleep;
    logic       cmd_accepted;
    logic       buf_overflow;
    logic [7:0] lfsr;
    logic       m_pwr;
    logic       m_soft;
    logic       m_sleep;
    logic       m_been_on;
    int         miscompares;
    int         n_tests;
    int         acc_cnt;
    int         ovf_cnt;
    int         ovf0;
    logic       q_acc[$];

    rpcr_term term (.clk(sys_clk), .ser_rxd(ser_rxd));

    rpcr_top dut (
        .SYS_CLK             (sys_clk),
        .RST                 (rst),
        .SER_RXD             (ser_rxd),
        .RPWR_JUMPER_EN      (jumper_en),
        .REMOTE_POWER_PERMIT (permit),
        .SHUTDOWN_DONE       (shutdown_done),
        .SYS_POWER_ON        (sys_power_on),
        .SOFT_OFF_REQ        (soft_off_req),
        .CTRL_SLEEP          (ctrl_sleep),
        .CMD_ACCEPTED        (cmd_accepted),
        .BUF_OVERFLOW        (buf_overflow)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // pulse outputs stand one cycle, so count them at every edge
    always @(posedge sys_clk)
    begin
        if (cmd_accepted === 1'b1) acc_cnt++;
        if (buf_overflow === 1'b1) ovf_cnt++;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk_state();
        check(16'(sys_power_on), 16'(m_pwr));
        check(16'(soft_off_req), 16'(m_soft));
        check(16'(ctrl_sleep), 16'(m_sleep));
    endtask

    // sends one command at a random rate and gap, then compares with the model
    task automatic run_cmd(input rpcr_pkg::rpcr_cmd_t k, input string name);
        logic [79:0] s;
        int          len;
        int          p;
        int          a0;
        logic        ok;
        logic        on_ok;
        lfsr = lfsr_next(lfsr);
        p = 32 + int'(lfsr[2:0]);
        s = (k == rpcr_pkg::CMD_ON) ? 80'(rpcr_pkg::CMD_ON_STR) :
            (k == rpcr_pkg::CMD_OFF) ? 80'(rpcr_pkg::CMD_OFF_STR) :
            (k == rpcr_pkg::CMD_TON) ? 80'(rpcr_pkg::CMD_TON_STR) : rpcr_pkg::CMD_SLEEP_STR;
        len = (k == rpcr_pkg::CMD_ON) ? rpcr_pkg::LEN_ON :
              (k == rpcr_pkg::CMD_SLEEP) ? rpcr_pkg::LEN_SLEEP : rpcr_pkg::LEN_OFF;
        ok = jumper_en & (m_been_on ? (permit & ~m_sleep) : (k == rpcr_pkg::CMD_ON));
        q_acc.push_back(ok);
        a0 = acc_cnt;
        term.send_cmd(s, len, p, int'(lfsr[5:3]));
        repeat (p) @(negedge sys_clk);
        on_ok = ok & (k == rpcr_pkg::CMD_ON);
        if (on_ok) m_been_on = 1'b1;
        if (ok && k == rpcr_pkg::CMD_OFF) m_soft = m_pwr;
        if (ok && k == rpcr_pkg::CMD_TON) m_soft = 1'b0;
        m_pwr = on_ok | (m_pwr & ~(ok & (k == rpcr_pkg::CMD_TON)));
        if (ok && k == rpcr_pkg::CMD_SLEEP) m_sleep = 1'b1;
        check(16'(acc_cnt - a0), 16'(q_acc.pop_front()));
        chk_state();
        $display("test done: %s", name);
    endtask

    // ----------------------------------------------------------------
    // watchdog, sized well above the longest expected run
    // ----------------------------------------------------------------
    initial
    begin
        repeat (95000) @(posedge sys_clk);
        miscompares++;
        $display("watchdog expired");
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        jumper_en = 1'b1;
        permit = 1'b0;
        shutdown_done = 1'b0;
        lfsr = 8'h59;
        {m_pwr, m_soft, m_sleep, m_been_on} = 4'h0;
        {miscompares, n_tests, acc_cnt, ovf_cnt} = {32'h0, 32'h0, 32'h0, 32'h0};
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        check(16'({sys_power_on, soft_off_req, ctrl_sleep}), 16'h0000);
        run_cmd(rpcr_pkg::CMD_OFF, "off before first power-up");
        run_cmd(rpcr_pkg::CMD_ON, "first power-on, permit clear");
        run_cmd(rpcr_pkg::CMD_OFF, "permit clear blocks");
        permit = 1'b1;
        run_cmd(rpcr_pkg::CMD_OFF, "soft off request");
        shutdown_done = 1'b1;
        @(negedge sys_clk);
        shutdown_done = 1'b0;
        repeat (3) @(negedge sys_clk);
        {m_pwr, m_soft} = 2'b00;
        chk_state();
        run_cmd(rpcr_pkg::CMD_ON, "power on again");
        run_cmd(rpcr_pkg::CMD_OFF, "soft off before immediate off");
        run_cmd(rpcr_pkg::CMD_TON, "immediate off");
        run_cmd(rpcr_pkg::CMD_SLEEP, "sleep");
        run_cmd(rpcr_pkg::CMD_ON, "ignored while asleep");
        // escape takes one slot, so the fourteenth return is the fifteenth byte
        ovf0 = ovf_cnt;
        term.send_byte(rpcr_pkg::CH_ESC, 36, 2);
        repeat (13) term.send_byte(rpcr_pkg::CH_CR, 36, 2);
        repeat (40) @(negedge sys_clk);
        check(16'(ovf_cnt - ovf0), 16'h0000);
        term.send_byte(rpcr_pkg::CH_CR, 36, 2);
        repeat (40) @(negedge sys_clk);
        check(16'(ovf_cnt - ovf0), 16'h0001);
        chk_state();
        $display("test done: buffer overflow");
        permit = 1'b0;
        m_sleep = 1'b0;
        repeat (4) @(negedge sys_clk);
        permit = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk_state();
        run_cmd(rpcr_pkg::CMD_ON, "wake and power on");
        jumper_en = 1'b0;
        repeat (4) @(negedge sys_clk);
        run_cmd(rpcr_pkg::CMD_TON, "jumper disabled blocks");
        jumper_en = 1'b1;
        repeat (4) @(negedge sys_clk);
        run_cmd(rpcr_pkg::CMD_TON, "jumper restored");
        print_verdict();
    end
endmodule

// *** inc/rpcr_pkg.sv ***
// Shared constants and types of the remote power command receiver.
// Assumes a single 10 MHz system clock and an asynchronous active-high reset.
package rpcr_pkg;

    // ----------------------------------------------------------------
    // characters and command strings
    // ----------------------------------------------------------------
    localparam logic [7:0]  CH_ESC        = 8'h1b;
    localparam logic [7:0]  CH_CR         = 8'h0d;
    // the separator between command words is taken as a plain space
    localparam int          LEN_ON        = 8;
    localparam int          LEN_OFF       = 9;
    localparam int          LEN_TON       = 9;
    localparam int          LEN_SLEEP     = 10;
    localparam logic [63:0] CMD_ON_STR    = {8'h1b, "rsys on"};
    localparam logic [71:0] CMD_OFF_STR   = {8'h1b, "rsys off"};
    localparam logic [71:0] CMD_TON_STR   = {8'h1b, "rsys ton"};
    localparam logic [79:0] CMD_SLEEP_STR = {8'h1b, "pic sleep"};

    // ----------------------------------------------------------------
    // sizes, timing and reset values
    // ----------------------------------------------------------------
    localparam int          BUF_DEPTH     = 14;
    localparam int          CNT_W         = 16;
    localparam int          MIN_BIT_CYC   = 4;
    localparam logic        JUMPER_RST    = 1'b1;
    localparam logic        LINE_IDLE     = 1'b1;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rpcr_byte_t;

    typedef enum logic [2:0] {CMD_NONE, CMD_ON, CMD_OFF, CMD_TON, CMD_SLEEP} rpcr_cmd_t;
    typedef enum logic [2:0] {RX_IDLE, RX_MEAS, RX_START, RX_DATA, RX_STOP} rpcr_rx_st_t;
    typedef enum logic [1:0] {PS_OFF, PS_ON, PS_SHUT} rpcr_pwr_st_t;

endpackage

// *** rtl/rpcr_rx.sv ***
// Serial receiver with start-bit baud measurement, 8 data bits, no parity.
// Assumes the line pin is asynchronous; relearn comes from the same clock.
`timescale 1ns/100ps
module rpcr_rx #(
    parameter int CNT_W = rpcr_pkg::CNT_W
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // line and control
    input  wire logic                rxd_pin,
    input  wire logic                relearn,
    // received characters
    output rpcr_pkg::rpcr_byte_t     rx_byte,
    output logic                     locked
);

    // ----------------------------------------------------------------
    // line synchroniser
    // ----------------------------------------------------------------
    logic rxd_meta_r;
    logic rxd_r;
    logic rxd_d_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxd_meta_r <= rpcr_pkg::LINE_IDLE;
            rxd_r      <= rpcr_pkg::LINE_IDLE;
            rxd_d_r    <= rpcr_pkg::LINE_IDLE;
        end
        else
        begin
            rxd_meta_r <= rxd_pin;
            rxd_r      <= rxd_meta_r;
            rxd_d_r    <= rxd_r;
        end
    end

    wire line_fall = rxd_d_r & ~rxd_r;
    wire line_rise = ~rxd_d_r & rxd_r;

    // ----------------------------------------------------------------
    // receive state machine
    // ----------------------------------------------------------------
    rpcr_pkg::rpcr_rx_st_t st_r;
    logic [CNT_W-1:0]      tmr_r;
    logic [CNT_W-1:0]      period_r;
    logic [2:0]            bit_r;
    logic [7:0]            sh_r;
    logic                  locked_r;
    rpcr_pkg::rpcr_byte_t  out_r;

    wire             tmr_done = (tmr_r == '0);
    wire [CNT_W-1:0] half     = {1'b0, period_r[CNT_W-1:1]};
    wire [CNT_W-1:0] tmr_down = tmr_r - 1'b1;
    wire             meas_ok  = (tmr_r >= CNT_W'(rpcr_pkg::MIN_BIT_CYC));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r     <= rpcr_pkg::RX_IDLE;
            tmr_r    <= '0;
            period_r <= '0;
            bit_r    <= 3'h0;
            sh_r     <= 8'h00;
            locked_r <= 1'b0;
            out_r    <= '0;
        end
        else
        begin
            out_r.valid <= 1'b0;
            if (relearn)
                locked_r <= 1'b0;
            case (st_r)
                rpcr_pkg::RX_IDLE:
                    if (line_fall)
                    begin
                        // once locked, later start bits are only checked at mid-bit
                        st_r  <= locked_r ? rpcr_pkg::RX_START : rpcr_pkg::RX_MEAS;
                        tmr_r <= locked_r ? half : '0;
                    end
                rpcr_pkg::RX_MEAS:
                    if (line_rise)
                    begin
                        // low data bits after the start bit stretch the figure
                        st_r  <= meas_ok ? rpcr_pkg::RX_DATA : rpcr_pkg::RX_IDLE;
                        period_r <= tmr_r;
                        locked_r <= meas_ok;
                        tmr_r <= {1'b0, tmr_r[CNT_W-1:1]};
                        bit_r <= 3'h0;
                    end
                    else if (tmr_r != '1)
                        tmr_r <= tmr_r + 1'b1;
                rpcr_pkg::RX_START:
                    if (!tmr_done)
                        tmr_r <= tmr_down;
                    else
                    begin
                        st_r  <= rxd_r ? rpcr_pkg::RX_IDLE : rpcr_pkg::RX_DATA;
                        tmr_r <= period_r;
                        bit_r <= 3'h0;
                    end
                rpcr_pkg::RX_DATA:
                    if (!tmr_done)
                        tmr_r <= tmr_down;
                    else
                    begin
                        sh_r  <= {rxd_r, sh_r[7:1]};
                        tmr_r <= period_r;
                        bit_r <= bit_r + 1'b1;
                        if (bit_r == 3'h7)
                            st_r <= rpcr_pkg::RX_STOP;
                    end
                rpcr_pkg::RX_STOP:
                    if (!tmr_done)
                        tmr_r <= tmr_down;
                    else
                    begin
                        // framing errors are dropped silently
                        st_r       <= rpcr_pkg::RX_IDLE;
                        out_r.valid <= rxd_r;
                        out_r.data  <= sh_r;
                    end
                default:
                    st_r <= rpcr_pkg::RX_IDLE;
            endcase
        end
    end

    assign rx_byte = out_r;
    assign locked  = locked_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_rx_meas_period: assert property (@(posedge clk) disable iff (rst)
        (st_r == rpcr_pkg::RX_MEAS && line_rise && meas_ok && !relearn)
        |=> (locked_r && period_r == $past(tmr_r) && st_r == rpcr_pkg::RX_DATA))
        else $error("start bit width not taken as bit period");

    a_rx_valid_stop: assert property (@(posedge clk) disable iff (rst)
        out_r.valid |-> ($past(st_r) == rpcr_pkg::RX_STOP && $past(rxd_r)))
        else $error("character delivered without a good stop bit");

endmodule

// *** rtl/rpcr_top.sv ***
// Remote power command receiver: watches the first serial port's receive line.
// Assumes the permit bit comes from firmware logic on SYS_CLK; jumper is a pin.
// Behaviour
// - The receive line is watched all the time, apart from the system's own UART.
// - Escape-prefixed commands switch power on, off via soft power-down, or off at once.
// - The sleep command makes the controller ignore later power commands until the permit bit is cleared.
// - With the jumper enabled, power-on is always accepted before the first power-up.
// - The enable jumper reads as enabled by default.
// - After power-up with the permit bit set, commands act only while not asleep.
// - After power-up with the permit bit clear, no command acts.
// - Clearing then setting the permit bit wakes the controller from sleep.
// - The bit rate is learnt from the start bit width of each command's first character.
// - A first character with low bits clear can give a wrong bit rate.
// - Input buffer overflow resets the controller; about fifteen returns force it.
`timescale 1ns/100ps
module rpcr_top #(
    parameter int BUF_DEPTH = rpcr_pkg::BUF_DEPTH
) (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST,
    // serial line
    input  wire logic SER_RXD,
    // system side
    input  wire logic RPWR_JUMPER_EN,
    input  wire logic REMOTE_POWER_PERMIT,
    input  wire logic SHUTDOWN_DONE,
    // power control
    output logic      SYS_POWER_ON,
    output logic      SOFT_OFF_REQ,
    // status
    output logic      CTRL_SLEEP,
    output logic      CMD_ACCEPTED,
    output logic      BUF_OVERFLOW
);

    localparam int CW = $clog2(BUF_DEPTH + 1);
    localparam int BW = 8 * BUF_DEPTH;

    // ----------------------------------------------------------------
    // jumper synchroniser
    // ----------------------------------------------------------------
    logic jmp_meta_r;
    logic jmp_r;

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            jmp_meta_r <= rpcr_pkg::JUMPER_RST;
            jmp_r      <= rpcr_pkg::JUMPER_RST;
        end
        else
        begin
            jmp_meta_r <= RPWR_JUMPER_EN;
            jmp_r      <= jmp_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    rpcr_pkg::rpcr_byte_t rx_b;
    logic                 relearn_r;

    // independent of the system UART, so it listens even with power off
    rpcr_rx #(
        .CNT_W   (rpcr_pkg::CNT_W)
    ) u_rx (
        .clk     (SYS_CLK),
        .rst     (RST),
        .rxd_pin (SER_RXD),
        .relearn (relearn_r),
        .rx_byte (rx_b),
        .locked  ()
    );

    // ----------------------------------------------------------------
    // input buffer and command decode
    // ----------------------------------------------------------------
    logic [BW-1:0] buf_r;
    logic [CW-1:0] cnt_r;

    wire is_esc = rx_b.valid && (rx_b.data == rpcr_pkg::CH_ESC);
    wire is_cr  = rx_b.valid && (rx_b.data == rpcr_pkg::CH_CR);

    wire hit_on    = (cnt_r == CW'(rpcr_pkg::LEN_ON))
                   && (buf_r[8*rpcr_pkg::LEN_ON-1:0] == rpcr_pkg::CMD_ON_STR);
    wire hit_off   = (cnt_r == CW'(rpcr_pkg::LEN_OFF))
                   && (buf_r[8*rpcr_pkg::LEN_OFF-1:0] == rpcr_pkg::CMD_OFF_STR);
    wire hit_ton   = (cnt_r == CW'(rpcr_pkg::LEN_TON))
                   && (buf_r[8*rpcr_pkg::LEN_TON-1:0] == rpcr_pkg::CMD_TON_STR);
    wire hit_sleep = (cnt_r == CW'(rpcr_pkg::LEN_SLEEP))
                   && (buf_r[8*rpcr_pkg::LEN_SLEEP-1:0] == rpcr_pkg::CMD_SLEEP_STR);

    rpcr_pkg::rpcr_cmd_t cmd;
    assign cmd = !is_cr    ? rpcr_pkg::CMD_NONE  :
                 hit_on    ? rpcr_pkg::CMD_ON    :
                 hit_off   ? rpcr_pkg::CMD_OFF   :
                 hit_ton   ? rpcr_pkg::CMD_TON   :
                 hit_sleep ? rpcr_pkg::CMD_SLEEP : rpcr_pkg::CMD_NONE;

    wire cmd_hit  = (cmd != rpcr_pkg::CMD_NONE);
    wire buf_full = (cnt_r == CW'(BUF_DEPTH));
    // unmatched returns stay in the buffer, so a run of them overflows it
    wire overflow = rx_b.valid && !is_esc && !cmd_hit && buf_full;

    // ----------------------------------------------------------------
    // acceptance
    // ----------------------------------------------------------------
    rpcr_pkg::rpcr_pwr_st_t pst_r;
    logic                   been_on_r;
    logic                   sleep_r;

    // before the first power-up only power-on counts, and the permit is ignored
    wire may_act = jmp_r && (!been_on_r ? (cmd == rpcr_pkg::CMD_ON)
                                        : (REMOTE_POWER_PERMIT && !sleep_r));
    wire act     = cmd_hit && may_act;

    // ----------------------------------------------------------------
    // buffer update
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            buf_r     <= '0;
            cnt_r     <= '0;
            relearn_r <= 1'b0;
        end
        else
        begin
            // every return opens a new command, so the rate is learnt again
            relearn_r <= is_cr || overflow;
            if (overflow || cmd_hit)
            begin
                buf_r <= '0;
                cnt_r <= '0;
            end
            else if (is_esc)
            begin
                buf_r <= {{(BW-8){1'b0}}, rpcr_pkg::CH_ESC};
                cnt_r <= CW'(1);
            end
            else if (rx_b.valid)
            begin
                buf_r <= {buf_r[BW-9:0], rx_b.data};
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // power state and sleep
    // ----------------------------------------------------------------
    logic power_r;
    logic soft_r;
    logic acc_r;
    logic ovf_r;

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            pst_r     <= rpcr_pkg::PS_OFF;
            power_r   <= 1'b0;
            soft_r    <= 1'b0;
            been_on_r <= 1'b0;
            sleep_r   <= 1'b0;
            acc_r     <= 1'b0;
            ovf_r     <= 1'b0;
        end
        else
        begin
            acc_r <= act;
            ovf_r <= overflow;
            // a low permit bit wakes the controller; setting it again re-enables
            if (!REMOTE_POWER_PERMIT)
                sleep_r <= 1'b0;
            else if (act && cmd == rpcr_pkg::CMD_SLEEP)
                sleep_r <= 1'b1;
            case (pst_r)
                rpcr_pkg::PS_OFF:
                    if (act && cmd == rpcr_pkg::CMD_ON)
                    begin
                        pst_r     <= rpcr_pkg::PS_ON;
                        power_r   <= 1'b1;
                        been_on_r <= 1'b1;
                    end
                rpcr_pkg::PS_ON:
                    if (act && cmd == rpcr_pkg::CMD_OFF)
                    begin
                        pst_r  <= rpcr_pkg::PS_SHUT;
                        soft_r <= 1'b1;
                    end
                    else if (act && cmd == rpcr_pkg::CMD_TON)
                    begin
                        pst_r   <= rpcr_pkg::PS_OFF;
                        power_r <= 1'b0;
                    end
                rpcr_pkg::PS_SHUT:
                    // an immediate-off overrides a slow shutdown
                    if (SHUTDOWN_DONE || (act && cmd == rpcr_pkg::CMD_TON))
                    begin
                        pst_r   <= rpcr_pkg::PS_OFF;
                        power_r <= 1'b0;
                        soft_r  <= 1'b0;
                    end
                default:
                    pst_r <= rpcr_pkg::PS_OFF;
            endcase
        end
    end

    assign SYS_POWER_ON = power_r;
    assign SOFT_OFF_REQ = soft_r;
    assign CTRL_SLEEP   = sleep_r;
    assign CMD_ACCEPTED = acc_r;
    assign BUF_OVERFLOW = ovf_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_first_power_on: assert property (@(posedge SYS_CLK) disable iff (RST)
        (!been_on_r && jmp_r && cmd == rpcr_pkg::CMD_ON) |=> (power_r && been_on_r))
        else $error("first power-on not accepted");

    a_sleep_ignores: assert property (@(posedge SYS_CLK) disable iff (RST)
        (sleep_r && been_on_r) |-> (!act ##1 !acc_r))
        else $error("command acted on while asleep");

    a_permit_off: assert property (@(posedge SYS_CLK) disable iff (RST)
        (been_on_r && !REMOTE_POWER_PERMIT && cmd_hit) |=> ($stable(power_r) && !acc_r))
        else $error("command acted on with permit clear");

    a_wake_permit: assert property (@(posedge SYS_CLK) disable iff (RST)
        (!REMOTE_POWER_PERMIT ##1 REMOTE_POWER_PERMIT) |-> !sleep_r)
        else $error("sleep survived a permit clear");

    a_soft_off: assert property (@(posedge SYS_CLK) disable iff (RST)
        (act && cmd == rpcr_pkg::CMD_OFF && pst_r == rpcr_pkg::PS_ON)
        |=> (soft_r && power_r && pst_r == rpcr_pkg::PS_SHUT))
        else $error("soft off did not keep power during shutdown");

    a_soft_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
        (soft_r && !SHUTDOWN_DONE && !(act && cmd == rpcr_pkg::CMD_TON))
        |=> (soft_r && power_r))
        else $error("shutdown request dropped early");

    a_soft_done: assert property (@(posedge SYS_CLK) disable iff (RST)
        (soft_r && SHUTDOWN_DONE) |=> (!soft_r && !power_r))
        else $error("power kept after shutdown finished");

    a_hard_off: assert property (@(posedge SYS_CLK) disable iff (RST)
        (act && cmd == rpcr_pkg::CMD_TON && pst_r != rpcr_pkg::PS_OFF)
        |=> (!power_r && !soft_r && pst_r == rpcr_pkg::PS_OFF))
        else $error("immediate off did not drop power");

    a_ovf_reset: assert property (@(posedge SYS_CLK) disable iff (RST)
        overflow |=> (ovf_r && cnt_r == '0 && relearn_r) ##1 !ovf_r)
        else $error("overflow did not reset the controller");

    a_cr_relearn: assert property (@(posedge SYS_CLK) disable iff (RST)
        is_cr |=> relearn_r)
        else $error("return did not restart rate learning");

    c_power_on: cover property (@(posedge SYS_CLK) disable iff (RST)
        $rose(power_r));
    c_soft_done: cover property (@(posedge SYS_CLK) disable iff (RST)
        soft_r ##1 !soft_r && !power_r);
    c_sleep_wake: cover property (@(posedge SYS_CLK) disable iff (RST)
        sleep_r ##[1:1000] !sleep_r);
    c_overflow: cover property (@(posedge SYS_CLK) disable iff (RST)
        ovf_r);

endmodule
